// File: src/io_space_register_decode.sv
/*
  Low I/O register space of the core: decode, storage, status flags and
  single-bit set, clear and test. Holds ports B/C/D, flag registers, mask,
  general purpose, nonvolatile control, prescaler and timer0 registers.
  Assumes the core presents one request per cycle and takes the answer one
  cycle later; peripherals behind the registers sit outside.
*/
`timescale 1ns/1ns
module io_space_register_decode
  import io_space_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire core_req_t    req,
  output core_resp_t        resp,
  input  wire pins_t        pins_in,
  input  wire flag_vec_t    flag_events,
  output flag_vec_t         flags,
  output periph_ctrl_t      ctrl
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  decode_t    dec;
  logic [7:0] store [IO_REGS];
  logic [7:0] cur_byte;
  logic [7:0] bit_mask;
  logic [7:0] byte_wr;
  logic [7:0] clear_vec;
  logic [7:0] st_mask;
  logic       store_we;
  logic       cur_bit;
  logic       next_skip;
  logic [7:0] next_rdata;
  flag_vec_t  flag_clr;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  io_addr_decode u_decode (
    .req (req),
    .dec (dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read selection; unmapped indices and unimplemented bits give zero
  function automatic logic [7:0] read_reg(input logic [5:0] idx);
    case (idx)
      IDX_PIN_B:   read_reg = pins_in.b;
      IDX_PIN_C:   read_reg = pins_in.c & MASK_PORT_C;
      IDX_PIN_D:   read_reg = pins_in.d;
      IDX_T0_FLG:  read_reg = flags[0];
      IDX_T1_FLG:  read_reg = flags[1];
      IDX_T2_FLG:  read_reg = flags[2];
      IDX_PC_FLG:  read_reg = flags[3];
      IDX_EXT_FLG: read_reg = flags[4];
      default:     read_reg = store[idx] & store_mask(idx);
    endcase
  endfunction

  // Current content of the addressed register; a process, so that changes
  // of storage and flags seen only inside the function still wake it
  always_comb begin
    cur_byte = read_reg(dec.idx);
  end
  assign cur_bit  = cur_byte[req.bit_sel];

  ////////////////////////////////////////////////////////////////////////
  // Write data; a bit op rebuilds the byte from the current content
  assign bit_mask = bit_onehot(req.bit_sel);
  assign byte_wr  = dec.set ? (cur_byte | bit_mask)
                  : dec.clr ? (cur_byte & ~bit_mask)
                  : req.wdata;

  // Flag clears: only a written one counts, a bit set only its own bit, a bit clear none
  assign clear_vec = dec.set ? bit_mask
                   : dec.clr ? 8'h00
                   : req.wdata;

  // Storage write enable; reserved and read-only places absorb writes
  assign st_mask  = store_mask(dec.idx);
  assign store_we = dec.wr && (st_mask != 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // Status flag registers, one bank per flag address
  for (genvar g = 0; g < FLAG_REGS; g++) begin : flag_gen
    wire flag_hit = dec.wr && dec.idx == flag_idx(3'(g));
    assign flag_clr[g] = flag_hit ? clear_vec : 8'h00;

    w1c_flag_bank u_bank (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .mask    (flag_mask(3'(g))),
      .set     (flag_events[g]),
      .clr     (flag_clr[g]),
      .q       (flags[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Plain storage registers; only implemented bits change
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < IO_REGS; i++) begin
        store[i] <= RESET_VALUE;
      end
    end else if (ce && store_we) begin
      store[dec.idx] <= (store[dec.idx] & ~st_mask) | (byte_wr & st_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer data; reads have no side effect on any register
  assign next_rdata = dec.rd ? cur_byte : 8'h00;
  assign next_skip  = dec.test_high ? cur_bit
                    : dec.test_low ? ~cur_bit
                    : 1'b0;

  // Answer register, one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else if (ce) begin
      resp.valid <= req.valid;
      resp.hit   <= dec.hit;
      resp.ext   <= dec.ext;
      resp.skip  <= next_skip;
      resp.rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control outputs straight from the storage flops
  assign ctrl.dir_b    = store[IDX_DIR_B];
  assign ctrl.out_b    = store[IDX_OUT_B];
  assign ctrl.dir_c    = store[IDX_DIR_C];
  assign ctrl.out_c    = store[IDX_OUT_C];
  assign ctrl.dir_d    = store[IDX_DIR_D];
  assign ctrl.out_d    = store[IDX_OUT_D];
  assign ctrl.ext_mask = store[IDX_EXT_MSK];
  assign ctrl.gp0      = store[IDX_GP0];
  assign ctrl.nv_ctl   = store[IDX_NV_CTL];
  assign ctrl.nv_dat   = store[IDX_NV_DAT];
  assign ctrl.nv_adl   = store[IDX_NV_ADL];
  assign ctrl.nv_adh   = store[IDX_NV_ADH];
  assign ctrl.psc_ctl  = store[IDX_PSC_CTL];
  assign ctrl.t0_cta   = store[IDX_T0_CTA];
  assign ctrl.t0_ctb   = store[IDX_T0_CTB];
  assign ctrl.t0_cnt   = store[IDX_T0_CNT];
  assign ctrl.t0_cma   = store[IDX_T0_CMA];
  assign ctrl.t0_cmb   = store[IDX_T0_CMB];

endmodule // io_space_register_decode

// File: inc/io_space_pkg.sv
/*
  Constants, types and decode helpers for the low I/O register space.
  Assumes one core clock and an 8-bit data-space address from the core.
*/
package io_space_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Address map limits
  localparam logic [7:0] IO_LAST     = 8'h3F;  // Top of the I/O instruction range
  localparam logic [7:0] BIT_LAST    = 8'h1F;  // Top of the bit-addressable range
  localparam logic [7:0] DATA_OFFSET = 8'h20;  // I/O address to data address
  localparam logic [7:0] EXT_FIRST   = 8'h60;  // First extended register
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int         IO_REGS     = 64;
  localparam int         FLAG_REGS   = 5;

  // Register indices (I/O addresses)
  localparam logic [5:0] IDX_PIN_B   = 6'h03;
  localparam logic [5:0] IDX_DIR_B   = 6'h04;
  localparam logic [5:0] IDX_OUT_B   = 6'h05;
  localparam logic [5:0] IDX_PIN_C   = 6'h06;
  localparam logic [5:0] IDX_DIR_C   = 6'h07;
  localparam logic [5:0] IDX_OUT_C   = 6'h08;
  localparam logic [5:0] IDX_PIN_D   = 6'h09;
  localparam logic [5:0] IDX_DIR_D   = 6'h0A;
  localparam logic [5:0] IDX_OUT_D   = 6'h0B;
  localparam logic [5:0] IDX_T0_FLG  = 6'h15;
  localparam logic [5:0] IDX_T1_FLG  = 6'h16;
  localparam logic [5:0] IDX_T2_FLG  = 6'h17;
  localparam logic [5:0] IDX_PC_FLG  = 6'h1B;
  localparam logic [5:0] IDX_EXT_FLG = 6'h1C;
  localparam logic [5:0] IDX_EXT_MSK = 6'h1D;
  localparam logic [5:0] IDX_GP0     = 6'h1E;
  localparam logic [5:0] IDX_NV_CTL  = 6'h1F;
  localparam logic [5:0] IDX_NV_DAT  = 6'h20;
  localparam logic [5:0] IDX_NV_ADL  = 6'h21;
  localparam logic [5:0] IDX_NV_ADH  = 6'h22;
  localparam logic [5:0] IDX_PSC_CTL = 6'h23;
  localparam logic [5:0] IDX_T0_CTA  = 6'h24;
  localparam logic [5:0] IDX_T0_CTB  = 6'h25;
  localparam logic [5:0] IDX_T0_CNT  = 6'h26;
  localparam logic [5:0] IDX_T0_CMA  = 6'h27;
  localparam logic [5:0] IDX_T0_CMB  = 6'h28;

  // Implemented bits; everything else reads zero
  localparam logic [7:0] MASK_FULL    = 8'hFF;
  localparam logic [7:0] MASK_PORT_C  = 8'h7F;
  localparam logic [7:0] MASK_T0_FLG  = 8'h07;
  localparam logic [7:0] MASK_T1_FLG  = 8'h27;
  localparam logic [7:0] MASK_T2_FLG  = 8'h07;
  localparam logic [7:0] MASK_PC_FLG  = 8'h07;
  localparam logic [7:0] MASK_EXT     = 8'h03;
  localparam logic [7:0] MASK_NV_CTL  = 8'h3F;
  localparam logic [7:0] MASK_NV_ADH  = 8'h01;
  localparam logic [7:0] MASK_PSC_CTL = 8'h83;
  localparam logic [7:0] MASK_T0_CTA  = 8'hF3;
  localparam logic [7:0] MASK_T0_CTB  = 8'h0F;  // Force bits are strobes, read zero

  ////////////////////////////////////////////////////////////////////////
  // Core operations; each mem form (pointer, absolute, offset) maps to one
  typedef enum logic [3:0] {
    op_none, op_io_read, op_io_write, op_bit_set, op_bit_clear,
    op_skip_high, op_skip_low, op_mem_read, op_mem_write
  } op_t;

  typedef struct packed {
    logic       valid;
    op_t        op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic       ext;
    logic       skip;
    logic [7:0] rdata;
  } core_resp_t;

  typedef struct packed {
    logic       hit;
    logic       ext;
    logic       rd;
    logic       wr;
    logic       set;
    logic       clr;
    logic       test_high;
    logic       test_low;
    logic [5:0] idx;
  } decode_t;

  typedef struct packed {
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } pins_t;

  typedef logic [FLAG_REGS-1:0][7:0] flag_vec_t;

  typedef struct packed {
    logic [7:0] dir_b, out_b, dir_c, out_c, dir_d, out_d;
    logic [7:0] ext_mask, gp0, nv_ctl, nv_dat, nv_adl, nv_adh;
    logic [7:0] psc_ctl, t0_cta, t0_ctb, t0_cnt, t0_cma, t0_cmb;
  } periph_ctrl_t;

  ////////////////////////////////////////////////////////////////////////
  // Writable bits of plain storage registers; zero means not stored
  function automatic logic [7:0] store_mask(input logic [5:0] idx);
    case (idx)
      IDX_DIR_B, IDX_OUT_B, IDX_DIR_D, IDX_OUT_D,
      IDX_GP0, IDX_NV_DAT, IDX_NV_ADL, IDX_T0_CNT,
      IDX_T0_CMA, IDX_T0_CMB: store_mask = MASK_FULL;
      IDX_DIR_C, IDX_OUT_C:   store_mask = MASK_PORT_C;
      IDX_EXT_MSK:            store_mask = MASK_EXT;
      IDX_NV_CTL:             store_mask = MASK_NV_CTL;
      IDX_NV_ADH:             store_mask = MASK_NV_ADH;
      IDX_PSC_CTL:            store_mask = MASK_PSC_CTL;
      IDX_T0_CTA:             store_mask = MASK_T0_CTA;
      IDX_T0_CTB:             store_mask = MASK_T0_CTB;
      default:                store_mask = 8'h00;
    endcase
  endfunction

  // Flag slot to address and implemented bits
  function automatic logic [5:0] flag_idx(input logic [2:0] slot);
    case (slot)
      3'h0:    flag_idx = IDX_T0_FLG;
      3'h1:    flag_idx = IDX_T1_FLG;
      3'h2:    flag_idx = IDX_T2_FLG;
      3'h3:    flag_idx = IDX_PC_FLG;
      default: flag_idx = IDX_EXT_FLG;
    endcase
  endfunction

  function automatic logic [7:0] flag_mask(input logic [2:0] slot);
    case (slot)
      3'h0:    flag_mask = MASK_T0_FLG;
      3'h1:    flag_mask = MASK_T1_FLG;
      3'h2:    flag_mask = MASK_T2_FLG;
      3'h3:    flag_mask = MASK_PC_FLG;
      default: flag_mask = MASK_EXT;
    endcase
  endfunction

  function automatic logic [7:0] bit_onehot(input logic [2:0] sel);
    bit_onehot = 8'h01 << sel;
  endfunction

endpackage

// File: src/io_addr_decode.sv
/*
  Address decoder: turns one core request into a register index and flags.
  Assumes the request is stable for the cycle in which valid is high.
*/
`timescale 1ns/1ns
module io_addr_decode
  import io_space_pkg::*;
(
  input  core_req_t req,
  output decode_t   dec
);

  ////////////////////////////////////////////////////////////////////////
  // Operation classes
  wire       is_io   = req.op == op_io_read || req.op == op_io_write;
  wire       is_test = req.op == op_skip_high || req.op == op_skip_low;
  wire       is_bitw = req.op == op_bit_set || req.op == op_bit_clear;
  wire       is_mem  = req.op == op_mem_read || req.op == op_mem_write;

  // Range checks; mem below the offset belongs to the core register file
  wire       io_ok   = is_io && req.addr <= IO_LAST;
  wire       bit_ok  = (is_test || is_bitw) && req.addr <= BIT_LAST;
  wire       mem_io  = is_mem && req.addr >= DATA_OFFSET && req.addr < EXT_FIRST;
  wire       mem_ext = is_mem && req.addr >= EXT_FIRST;
  wire [7:0] mem_rel = req.addr - DATA_OFFSET;
  wire       hit     = req.valid && (io_ok || bit_ok || mem_io);

  // Decoded request
  assign dec.hit       = hit;
  assign dec.ext       = req.valid && mem_ext;
  assign dec.idx       = mem_io ? mem_rel[5:0] : req.addr[5:0];
  assign dec.rd        = hit && (req.op == op_io_read || req.op == op_mem_read || is_test);
  assign dec.wr        = hit && (req.op == op_io_write || req.op == op_mem_write || is_bitw);
  assign dec.set       = hit && req.op == op_bit_set;
  assign dec.clr       = hit && req.op == op_bit_clear;
  assign dec.test_high = hit && req.op == op_skip_high;
  assign dec.test_low  = hit && req.op == op_skip_low;

endmodule // io_addr_decode

// File: src/w1c_flag_bank.sv
/*
  One 8-bit status flag register: hardware sets, a written one clears.
  Assumes set pulses are synchronous to ref_clk.
*/
`timescale 1ns/1ns
module w1c_flag_bank
  import io_space_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] mask,
  input  wire logic [7:0] set,
  input  wire logic [7:0] clr,
  output logic      [7:0] q
);

  // A set in the same cycle as its clear wins, so no event is lost
  wire [7:0] next_q = ((q & ~clr) | set) & mask;

  ////////////////////////////////////////////////////////////////////////
  // Flag storage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (ce) begin
      q <= next_q;
    end
  end

endmodule // w1c_flag_bank

// File: verif/io_space_monitor.sv
/* Checker for the low I/O register decode; sees only the top ports.
   Assumes one clock, ce held high by the bench except in its freeze test, answers one cycle later. */
`timescale 1ns/1ns
module io_space_monitor
  import io_space_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         ce,
  input wire core_req_t    req,
  input wire core_resp_t   resp,
  input wire pins_t        pins_in,
  input wire flag_vec_t    flag_events,
  input wire flag_vec_t    flags,
  input wire periph_ctrl_t ctrl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Request classes taken at this edge
  wire logic rq      = ce && req.valid;
  wire logic io_op   = req.op inside {op_io_read, op_io_write};
  wire logic mem_op  = req.op inside {op_mem_read, op_mem_write};
  wire logic skip_op = req.op inside {op_skip_high, op_skip_low};
  wire logic bit_op  = skip_op || (req.op inside {op_bit_set, op_bit_clear});
  ////////////////////////////////////////////////////////////////////////
  // Answer timing and range refusals
  a_resp_follows: assert property (ce |=> resp.valid == $past(req.valid))
    else $error("answer valid does not follow request");
  a_io_range: assert property (rq && io_op && req.addr > IO_LAST |=> !resp.hit)
    else $error("io op above range was taken");
  a_mem_low: assert property (rq && mem_op && req.addr < DATA_OFFSET |=> !resp.hit)
    else $error("mem op below offset was taken");
  a_ext_only: assert property (rq && mem_op && req.addr >= EXT_FIRST |=> resp.ext && !resp.hit)
    else $error("extended access not routed away");
  a_bit_range: assert property (rq && bit_op && req.addr > BIT_LAST |=> !resp.hit && !resp.skip)
    else $error("bit op above range was taken");
  a_skip_only: assert property (rq && !skip_op |=> !resp.skip)
    else $error("skip raised by a non-test op");
  // Flag and bit side effects; set pulses excluded since set wins
  a_w1c_zero: assert property (rq && req.op == op_io_write && req.addr == 8'h16 &&
    req.wdata == 8'h00 && flag_events[1] == 8'h00 |=> flags[1] == $past(flags[1]))
    else $error("zero write changed a flag");
  a_set_keeps: assert property (rq && req.op == op_bit_set && req.addr == 8'h05
    |=> ctrl.out_b == ($past(ctrl.out_b) | (8'h01 << $past(req.bit_sel))))
    else $error("bit set disturbed other bits");
  a_flag_single: assert property (rq && req.op == op_bit_set && req.addr == 8'h16 &&
    flag_events[1] == 8'h00 |=> flags[1] == ($past(flags[1]) & ~(8'h01 << $past(req.bit_sel))))
    else $error("bit set on flags cleared other flags");
  a_miss_zero: assert property (resp.valid && !resp.hit |-> resp.rdata == 8'h00)
    else $error("miss returned nonzero data");
  a_ce_freeze: assert property (!ce |=> ctrl == $past(ctrl) && flags == $past(flags))
    else $error("state changed while clock enable low");
  c_skip: cover property (rq && skip_op);
  c_freeze: cover property (!ce && req.valid);
  c_ext: cover property (resp.ext);
  c_flag_bit: cover property (rq && req.op == op_bit_set && req.addr == 8'h16);
endmodule // io_space_monitor

// File: verif/io_core_model.sv
/* Core model: issues one I/O or data-space access at a time.
   Assumes the answer stands in the cycle after the taking edge. */
`timescale 1ns/1ns
module io_core_model
  import io_space_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire core_resp_t resp,
  output core_req_t       req
);
  initial req = '0;
  // Drive after the falling edge, read the answer while it stands; released
  // address, bit and data lines show inverted values so nothing leans on stale data.
  // Callers keep reserved bits zero and never write reserved places.
  task automatic access(input op_t op, input logic [7:0] addr, input logic [2:0] sel,
                        input logic [7:0] wd, output core_resp_t r);
    @(negedge ref_clk);
    req <= {1'b1, op, addr, sel, wd};
    @(posedge ref_clk);
    @(negedge ref_clk);
    r = resp;
    req <= {1'b0, op, ~addr, ~sel, ~wd};
  endtask
endmodule // io_core_model

// File: verif/io_space_register_decode_bench.sv
/* Self-checking bench for the low I/O register decode.
   Assumes the core model drives req and the bench drives pins and events. */
`timescale 1ns/1ns
module io_space_register_decode_bench
  import io_space_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rst     = 1'b1;
  logic         ce      = 1'b1;
  core_req_t    req;
  core_resp_t   resp, r;
  pins_t        pins_in = {8'h5A, 8'hBC, 8'hC3};
  flag_vec_t    flag_events = '0;
  flag_vec_t    flags;
  periph_ctrl_t ctrl;
  int           n_errors = 0, n_tests = 0;
  logic [7:0]   e;

  always #5 ref_clk = ~ref_clk;

  io_space_register_decode u_io_space_register_decode (.ref_clk(ref_clk), .rst(rst),
    .ce(ce), .req(req), .resp(resp), .pins_in(pins_in), .flag_events(flag_events),
    .flags(flags), .ctrl(ctrl));
  io_core_model u_io_core_model (.ref_clk(ref_clk), .resp(resp), .req(req));
  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic acc(input op_t op, input logic [7:0] a, input logic [2:0] s,
                     input logic [7:0] w);
    u_io_core_model.access(op, a, s, w, r);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk("ctrl", 8'h00, {7'h00, |ctrl});
    chk("flags", 8'h00, {7'h00, |flags});
    chk("resp", 8'h00, {7'h00, |resp});
    $display("t_reset done");
  endtask
  task automatic t_io_space;
    acc(op_io_write, 8'h05, 3'h0, 8'hA5); chk("out_b", 8'hA5, ctrl.out_b);
    acc(op_mem_read, 8'h25, 3'h0, 8'h00); chk("rd 25", 8'hA5, r.rdata);
    acc(op_mem_write, 8'h48, 3'h0, 8'h77); acc(op_io_read, 8'h28, 3'h0, 8'h00);
    chk("rd 28", 8'h77, r.rdata);
    acc(op_io_read, 8'h40, 3'h0, 8'h00); chk("hit 40", 8'h00, {7'h00, r.hit});
    acc(op_mem_read, 8'h1F, 3'h0, 8'h00); chk("hit m1F", 8'h00, {7'h00, r.hit});
    acc(op_io_read, 8'h06, 3'h0, 8'h00); chk("pin c", 8'h3C, r.rdata);
    acc(op_io_read, 8'h0C, 3'h0, 8'h00); chk("rd 0C", 8'h00, r.rdata);
    $display("t_io_space done");
  endtask
  task automatic t_ext;
    acc(op_mem_read, 8'h60, 3'h0, 8'h00); chk("ext 60", 8'h02, {6'h00, r.ext, r.hit});
    acc(op_mem_write, 8'hFF, 3'h0, 8'h12); chk("ext FF", 8'h02, {6'h00, r.ext, r.hit});
    acc(op_io_read, 8'h60, 3'h0, 8'h00); chk("io 60", 8'h00, {6'h00, r.ext, r.hit});
    $display("t_ext done");
  endtask
  task automatic t_bits;
    e = 8'h00;
    for (int i = 0; i < 8; i++) begin
      e = e | (8'h01 << i);
      acc(op_bit_set, 8'h0A, 3'(i), 8'h00); chk("dir_d", e, ctrl.dir_d);
    end
    acc(op_bit_clear, 8'h0A, 3'h3, 8'h00); chk("dir_d clr", 8'hF7, ctrl.dir_d);
    acc(op_skip_high, 8'h0A, 3'h3, 8'h00); chk("skip hi", 8'h00, {7'h00, r.skip});
    acc(op_skip_low, 8'h0A, 3'h3, 8'h00); chk("skip lo", 8'h01, {7'h00, r.skip});
    acc(op_skip_high, 8'h0A, 3'h7, 8'h00); chk("skip hi7", 8'h01, {7'h00, r.skip});
    acc(op_bit_set, 8'h05, 3'h6, 8'h00); chk("out_b", 8'hE5, ctrl.out_b);
    acc(op_bit_set, 8'h1F, 3'h2, 8'h00); chk("nv_ctl", 8'h04, ctrl.nv_ctl);
    acc(op_bit_set, 8'h20, 3'h0, 8'h00); chk("hit 20", 8'h00, {7'h00, r.hit});
    chk("nv_dat", 8'h00, ctrl.nv_dat);
    $display("t_bits done");
  endtask
  task automatic t_flags;
    @(negedge ref_clk);
    flag_events[1] = 8'h27;
    flag_events[4] = 8'hFF;
    @(negedge ref_clk);
    flag_events = '0;
    chk("flags1", 8'h27, flags[1]);
    chk("flags4", 8'h03, flags[4]);
    acc(op_io_write, 8'h16, 3'h0, 8'h00); chk("w0", 8'h27, flags[1]);
    acc(op_bit_set, 8'h16, 3'h0, 8'h00); chk("set0", 8'h26, flags[1]);
    acc(op_bit_clear, 8'h16, 3'h1, 8'h00); chk("clr1", 8'h26, flags[1]);
    acc(op_skip_low, 8'h16, 3'h2, 8'h00); chk("skip f", 8'h00, {7'h00, r.skip});
    acc(op_mem_write, 8'h36, 3'h0, 8'h20); chk("w1", 8'h06, flags[1]);
    acc(op_io_write, 8'h1C, 3'h0, 8'h01); chk("flags4", 8'h02, flags[4]);
    $display("t_flags done");
  endtask
  task automatic t_freeze;
    @(negedge ref_clk);
    ce = 1'b0;
    flag_events[0] = 8'h01;
    acc(op_io_write, 8'h1E, 3'h0, 8'h55);
    ce = 1'b1;
    flag_events = '0;
    chk("gp0 frozen", 8'h00, ctrl.gp0);
    chk("flags0 frozen", 8'h00, flags[0]);
    acc(op_io_write, 8'h1E, 3'h0, 8'h55); chk("gp0", 8'h55, ctrl.gp0);
    $display("t_freeze done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_io_space;
    t_ext;
    t_bits;
    t_flags;
    t_freeze;
    test_done;
  end
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule // io_space_register_decode_bench

bind io_space_register_decode io_space_monitor u_io_space_monitor (.ref_clk(ref_clk),
  .rst(rst), .ce(ce), .req(req), .resp(resp), .pins_in(pins_in),
  .flag_events(flag_events), .flags(flags), .ctrl(ctrl));
